// ==== rtl/dcr_pkg.sv ====
package dcr_pkg;
  // command characters and reply bytes
  localparam logic [7:0] CMD_STATUS   = 8'h53;
  localparam logic [7:0] CMD_FRAME    = 8'h46;
  localparam logic [7:0] CMD_GAIN     = 8'h47;
  localparam logic [7:0] CMD_TYPE     = 8'h44;
  localparam logic [7:0] CMD_ROLL     = 8'h48;
  localparam logic [7:0] CMD_CONTRAST = 8'h4A;
  localparam logic [7:0] CMD_LIGHTS   = 8'h5A;
  localparam logic [7:0] CMD_BIAS     = 8'h42;
  localparam logic [7:0] CMD_INBUS    = 8'h59;
  localparam logic [7:0] BYTE_ACK     = 8'h2E;
  localparam logic [7:0] BYTE_NACK    = 8'h3F;
  // packet geometry in 16-bit words
  localparam logic [8:0] HDR_WORDS    = 9'h008;
  localparam logic [8:0] STATUS_WORDS = 9'h094;
  localparam logic [8:0] ECHO_WORDS   = 9'h1E0;
  localparam logic [8:0] AUX_IDX      = 9'h003;
  localparam logic [8:0] SWITCH_IDX   = 9'h007;
  localparam logic [3:0] BOARD_WORDS  = 4'hE;
  localparam logic [3:0] BIAS_SLOT    = 4'hB;
  // values
  localparam logic [15:0] CONTRAST_MAX = 16'h0FFF;
  localparam logic [15:0] BIAS_DEFAULT = 16'h0159;
  localparam logic [15:0] OTHER_BIAS   = 16'h0001;
  localparam logic [7:0]  IB_OFF       = 8'h02;
  localparam logic [7:0]  IB_PARALLEL  = 8'h04;
  // option switch bit positions and board count
  localparam int SW_BAUD0 = 0;
  localparam int SW_BAUD1 = 1;
  localparam int SW_PROTECT = 2;
  localparam int SW_FAN = 3;
  localparam int SW_AUX_BIAS = 4;
  localparam int SW_SLAVE = 5;
  localparam int SW_STREAM_STAT = 6;
  localparam int SW_STREAM_VOLT = 7;
  localparam int NUM_BOARDS = 10;

  typedef enum logic [1:0] {
    TBL_STATUS = 2'b00,
    TBL_FRAME  = 2'b01,
    TBL_GAIN   = 2'b10
  } dcr_tbl_type;

  typedef struct packed {
    dcr_tbl_type kind;
    logic [8:0]  index;
  } dcr_req_type;

  typedef struct packed {
    logic [11:0] contrast;
    logic [15:0] bias;
    logic [7:0]  ib_mode;
    logic        roll;
    logic        lights;
  } dcr_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARG1  = 3'b001,
    ST_ARG2  = 3'b010,
    ST_ONE   = 3'b011,
    ST_ID    = 3'b100,
    ST_FETCH = 3'b101,
    ST_LO    = 3'b110,
    ST_HI    = 3'b111
  } dcr_state_type;
endpackage

// ==== rtl/dcr_cmd.sv ====
`timescale 1ns/100ps
// Operation
// - packet words follow the one-byte identifier, low byte first.
// - accepted non-query commands get ack 0x2E, unknown ones get nack, ignored.
// - unused auxiliary bias word still takes two bytes in status.
// - switch word bits 0-7 mirror option switches, down reads 1.
// - option bits: baud select, protect, fan, aux, slave, streams.
// - switch word bits 8-15 carry address switches positions 1 to 8.
// - each board table is fourteen words in fixed order.
// - board word bits 0-3 zero-based board number, bits 4-7 zero.
// - board word bits 8-15 carry the eight board flags in order.
// - only the first board reports real bias; others report 1.
// - frame echo returns 0x46 and 480 frame words, 961 bytes.
// - frame echo reads only the control-bus frame buffer.
// - gain echo returns 0x47 and gain words, high byte zero.
// - type query returns echoed character plus two-byte type code.
// - roll command toggles rolling display, always replies ack.
// - contrast takes 0 to 0xFFF, 0 is maximum, ack or nack.
// - lights toggle blanks all lights; next toggle restores them.
// - bias setpoint only applies in manufacturing while active.
// - bias setpoint code is inversely related to bias voltage.
// - input-bus argument 2 off, 3 serial, 4 parallel.
// - input-bus mode cannot change while active.
module dcr_cmd #(
  parameter logic [15:0] DRIVER_TYPE = 16'h00A5  // arbitrary type code
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_valid,
  output logic                      rx_ready,
  output logic [7:0]                tx_data,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  input  wire logic                 active_mode,
  input  wire logic                 mfg_mode,
  input  wire logic [7:0]           opt_switch_up,
  input  wire logic [7:0]           addr_switch_up,
  input  wire logic [9:0][7:0]      board_flags,
  output dcr_pkg::dcr_req_type      tbl_req,
  input  wire logic [15:0]          tbl_data,
  output dcr_pkg::dcr_cfg_type      cfg,
  output logic [15:0]               switch_word,
  output logic                      baud_fixed
);
  dcr_pkg::dcr_state_type state_reg, state_next;
  dcr_pkg::dcr_req_type   req_reg, req_next;
  dcr_pkg::dcr_cfg_type   cfg_reg, cfg_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [7:0]  arg_reg, arg_next;
  logic [8:0]  cnt_reg, cnt_next;
  logic [3:0]  board_reg, board_next;
  logic [3:0]  slot_reg, slot_next;
  logic [15:0] word_reg, word_next;
  logic [7:0]  txd_reg, txd_next;
  logic        txv_reg, txv_next;
  logic        rdy_reg, rdy_next;
  logic        act_reg;
  logic        bfix_reg;
  logic [15:0] sw_meta_reg, sw_reg;
  logic        take, sent, last;
  logic [15:0] src_word, arg_word;
  // short local names for the sequencer states
  localparam dcr_pkg::dcr_state_type
    ST_IDLE = dcr_pkg::ST_IDLE, ST_ARG1 = dcr_pkg::ST_ARG1,
    ST_ARG2 = dcr_pkg::ST_ARG2, ST_ONE = dcr_pkg::ST_ONE,
    ST_ID = dcr_pkg::ST_ID, ST_FETCH = dcr_pkg::ST_FETCH,
    ST_LO = dcr_pkg::ST_LO, ST_HI = dcr_pkg::ST_HI;
  // switch pins are asynchronous; inverted at capture so down reads 1
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_meta_reg <= 16'h0000;
      sw_reg      <= 16'h0000;
      bfix_reg    <= 1'b0;
    end else begin
      sw_meta_reg <= ~{addr_switch_up, opt_switch_up};
      sw_reg      <= sw_meta_reg;
      bfix_reg    <= sw_reg[dcr_pkg::SW_BAUD0] & sw_reg[dcr_pkg::SW_BAUD1];
    end
  end
  assign take     = rx_valid & rdy_reg;
  assign sent     = txv_reg & tx_ready;
  assign arg_word = {rx_data, arg_reg};
  assign last     = (cmd_reg == dcr_pkg::CMD_STATUS)
                  ? (cnt_reg == dcr_pkg::STATUS_WORDS - 9'h001)
                  : (cnt_reg == dcr_pkg::ECHO_WORDS - 9'h001);
  // word source for the packet being streamed
  always_comb begin
    src_word = tbl_data;
    if (cmd_reg == dcr_pkg::CMD_STATUS) begin
      if (cnt_reg < dcr_pkg::HDR_WORDS) begin
        if (cnt_reg == dcr_pkg::AUX_IDX)
          src_word = 16'h0000;
        else if (cnt_reg == dcr_pkg::SWITCH_IDX)
          src_word = sw_reg;
      end else if (slot_reg == 4'h0) begin
        src_word = {board_flags[board_reg], 4'h0, board_reg};
      end else if (slot_reg == dcr_pkg::BIAS_SLOT && board_reg != 4'h0) begin
        src_word = dcr_pkg::OTHER_BIAS;
      end
    end else if (cmd_reg == dcr_pkg::CMD_GAIN) begin
      src_word = {8'h00, tbl_data[7:0]};
    end
  end
  // command sequencer and configuration
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    cfg_next   = cfg_reg;
    cmd_next   = cmd_reg;
    arg_next   = arg_reg;
    cnt_next   = cnt_reg;
    board_next = board_reg;
    slot_next  = slot_reg;
    word_next  = word_reg;
    txd_next   = txd_reg;
    txv_next   = txv_reg;
    if (active_mode && !act_reg)
      cfg_next.bias = dcr_pkg::BIAS_DEFAULT;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          cmd_next   = rx_data;
          cnt_next   = 9'h000;
          board_next = 4'h0;
          slot_next  = 4'h0;
          txv_next   = 1'b1;
          txd_next   = dcr_pkg::BYTE_ACK;
          state_next = ST_ONE;
          case (rx_data)
            dcr_pkg::CMD_STATUS, dcr_pkg::CMD_FRAME, dcr_pkg::CMD_GAIN: begin
              txd_next   = rx_data;
              state_next = ST_ID;
              req_next.index = 9'h000;
              req_next.kind  = (rx_data == dcr_pkg::CMD_STATUS)
                             ? dcr_pkg::TBL_STATUS
                             : (rx_data == dcr_pkg::CMD_FRAME)
                             ? dcr_pkg::TBL_FRAME : dcr_pkg::TBL_GAIN;
            end
            dcr_pkg::CMD_TYPE: begin
              txd_next   = rx_data;
              word_next  = DRIVER_TYPE;
              state_next = ST_ID;
            end
            dcr_pkg::CMD_ROLL: cfg_next.roll = ~cfg_reg.roll;
            dcr_pkg::CMD_LIGHTS: cfg_next.lights = ~cfg_reg.lights;
            dcr_pkg::CMD_CONTRAST, dcr_pkg::CMD_BIAS,
            dcr_pkg::CMD_INBUS: begin
              txv_next   = 1'b0;
              state_next = ST_ARG1;
            end
            default: txd_next = dcr_pkg::BYTE_NACK;
          endcase
        end
      end
      ST_ARG1: begin
        if (take) begin
          arg_next = rx_data;
          if (cmd_reg == dcr_pkg::CMD_INBUS) begin
            txv_next   = 1'b1;
            state_next = ST_ONE;
            if (!active_mode && rx_data >= dcr_pkg::IB_OFF
                && rx_data <= dcr_pkg::IB_PARALLEL) begin
              cfg_next.ib_mode = rx_data;
              txd_next = dcr_pkg::BYTE_ACK;
            end else begin
              txd_next = dcr_pkg::BYTE_NACK;
            end
          end else begin
            state_next = ST_ARG2;
          end
        end
      end
      ST_ARG2: begin
        if (take) begin
          txv_next   = 1'b1;
          txd_next   = dcr_pkg::BYTE_NACK;
          state_next = ST_ONE;
          if (cmd_reg == dcr_pkg::CMD_CONTRAST) begin
            if (arg_word <= dcr_pkg::CONTRAST_MAX) begin
              cfg_next.contrast = arg_word[11:0];
              txd_next = dcr_pkg::BYTE_ACK;
            end
          end else if (mfg_mode && active_mode) begin
            cfg_next.bias = arg_word;
            txd_next = dcr_pkg::BYTE_ACK;
          end
        end
      end
      ST_ONE: begin
        if (sent) begin
          txv_next   = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_ID: begin
        if (sent) begin
          if (cmd_reg == dcr_pkg::CMD_TYPE) begin
            txd_next   = word_reg[7:0];
            state_next = ST_LO;
          end else begin
            txv_next   = 1'b0;
            state_next = ST_FETCH;
          end
        end
      end
      // table read is combinational, so data is here this cycle
      ST_FETCH: begin
        word_next  = src_word;
        txd_next   = src_word[7:0];
        txv_next   = 1'b1;
        state_next = ST_LO;
      end
      ST_LO: begin
        if (sent) begin
          txd_next   = word_reg[15:8];
          state_next = ST_HI;
        end
      end
      ST_HI: begin
        if (sent) begin
          txv_next = 1'b0;
          if (cmd_reg == dcr_pkg::CMD_TYPE || last) begin
            state_next = ST_IDLE;
          end else begin
            cnt_next       = cnt_reg + 9'h001;
            req_next.index = cnt_reg + 9'h001;
            state_next     = ST_FETCH;
            if (cnt_reg >= dcr_pkg::HDR_WORDS) begin
              if (slot_reg == dcr_pkg::BOARD_WORDS - 4'h1) begin
                slot_next  = 4'h0;
                board_next = board_reg + 4'h1;
              end else begin
                slot_next = slot_reg + 4'h1;
              end
            end
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    rdy_next = (state_next == ST_IDLE) || (state_next == ST_ARG1)
            || (state_next == ST_ARG2);
  end
  // state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      req_reg   <= '{kind: dcr_pkg::TBL_STATUS, index: 9'h000};
      cfg_reg   <= '{contrast: 12'h000, bias: dcr_pkg::BIAS_DEFAULT,
                     ib_mode: dcr_pkg::IB_OFF, roll: 1'b0, lights: 1'b1};
      cmd_reg   <= 8'h00;
      arg_reg   <= 8'h00;
      cnt_reg   <= 9'h000;
      board_reg <= 4'h0;
      slot_reg  <= 4'h0;
      word_reg  <= 16'h0000;
      txd_reg   <= 8'h00;
      txv_reg   <= 1'b0;
      rdy_reg   <= 1'b0;
      act_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg   <= req_next;
      cfg_reg   <= cfg_next;
      cmd_reg   <= cmd_next;
      arg_reg   <= arg_next;
      cnt_reg   <= cnt_next;
      board_reg <= board_next;
      slot_reg  <= slot_next;
      word_reg  <= word_next;
      txd_reg   <= txd_next;
      txv_reg   <= txv_next;
      rdy_reg   <= rdy_next;
      act_reg   <= active_mode;
    end
  end
  assign rx_ready    = rdy_reg;
  assign tx_data     = txd_reg;
  assign tx_valid    = txv_reg;
  assign tbl_req     = req_reg;
  assign cfg         = cfg_reg;
  assign switch_word = sw_reg;
  assign baud_fixed  = bfix_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_unknown_nack: assert property (
    take && state_reg == ST_IDLE && rx_data == 8'h00
    |=> tx_valid && tx_data == dcr_pkg::BYTE_NACK)
    else $error("unknown command not nacked");
  a_roll_ack: assert property (
    take && state_reg == ST_IDLE && rx_data == dcr_pkg::CMD_ROLL
    |=> tx_data == dcr_pkg::BYTE_ACK && cfg.roll != $past(cfg.roll))
    else $error("roll not acked or toggled");
  a_packet_ident: assert property (
    take && state_reg == ST_IDLE && rx_data == dcr_pkg::CMD_FRAME
    |=> tx_valid && tx_data == dcr_pkg::CMD_FRAME)
    else $error("frame echo identifier wrong");
  a_gain_hi_zero: assert property (
    state_reg == ST_HI && cmd_reg == dcr_pkg::CMD_GAIN |-> tx_data == 8'h00)
    else $error("gain high byte not zero");
  a_aux_word: assert property (
    state_reg == ST_FETCH && cmd_reg == dcr_pkg::CMD_STATUS
    && cnt_reg == dcr_pkg::AUX_IDX |=> tx_data == 8'h00 ##0 word_reg == 0)
    else $error("aux bias word not zero");
  a_board_id: assert property (
    state_reg == ST_FETCH && cmd_reg == dcr_pkg::CMD_STATUS
    && cnt_reg >= dcr_pkg::HDR_WORDS && slot_reg == 4'h0
    |=> word_reg[7:0] == {4'h0, $past(board_reg)})
    else $error("board id field wrong");
  a_other_bias: assert property (
    state_reg == ST_FETCH && cmd_reg == dcr_pkg::CMD_STATUS
    && cnt_reg >= dcr_pkg::HDR_WORDS && slot_reg == dcr_pkg::BIAS_SLOT
    && board_reg != 4'h0 |=> word_reg == dcr_pkg::OTHER_BIAS)
    else $error("non-first board bias not one");
  a_inbus_locked: assert property (
    active_mode |=> $stable(cfg.ib_mode))
    else $error("input bus mode changed while active");
  a_lights_toggle: assert property (
    take && state_reg == ST_IDLE && rx_data == dcr_pkg::CMD_LIGHTS
    |=> cfg.lights == !$past(cfg.lights) && tx_valid
        && tx_data == dcr_pkg::BYTE_ACK)
    else $error("lights did not toggle");
  a_bias_default: assert property (
    $rose(active_mode) && state_reg != ST_ARG2
    |=> cfg.bias == dcr_pkg::BIAS_DEFAULT)
    else $error("bias default not restored");
  a_lo_then_hi: assert property (
    state_reg == ST_LO && sent |=> tx_data == $past(word_reg[15:8]))
    else $error("high byte not after low byte");
  c_status_done: cover property (
    state_reg == ST_HI && sent && last && cmd_reg == dcr_pkg::CMD_STATUS);
  c_type_query: cover property (
    state_reg == ST_HI && sent && cmd_reg == dcr_pkg::CMD_TYPE);
  c_inbus_nack: cover property (
    state_reg == ST_ARG1 && take && cmd_reg == dcr_pkg::CMD_INBUS
    && active_mode);
endmodule

// ==== tb/dcr_host.sv ====
`timescale 1ns/100ps
module dcr_host (
  input  wire logic       clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       slow
);
  logic [7:0] got_q[$];

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end

  // reply sink; slow mode stalls three cycles in four
  always @(negedge clk) begin
    tx_ready = slow ? (($urandom % 4) == 0) : (($urandom % 4) != 0);
    if (tx_valid && tx_ready)
      got_q.push_back(tx_data);
  end

  task automatic send(input logic [7:0] b);
    @(negedge clk);
    rx_data = b;
    rx_valid = 1'b1;
    while (!rx_ready) @(negedge clk);
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~b; // released line must not look like the last byte
  endtask
endmodule

// ==== tb/dcr_cmd_tb.sv ====
`timescale 1ns/100ps
module dcr_cmd_tb;
  localparam logic [15:0] TYPE_CODE = 16'h5A3C; // arbitrary type code
  logic                 clk, reset, rx_valid, rx_ready, tx_valid, tx_ready;
  logic                 active_mode, mfg_mode, slow, baud_fixed;
  logic [7:0]           rx_data, tx_data, opt_switch_up, addr_switch_up;
  logic [9:0][7:0]      board_flags;
  logic [15:0]          tbl_data, switch_word, salt;
  dcr_pkg::dcr_req_type tbl_req;
  dcr_pkg::dcr_cfg_type cfg;
  int                   error_cnt, compares, m_con, m_bias, m_ib;
  int                   m_roll, m_lit, exp_q[$];

  dcr_cmd #(.DRIVER_TYPE(TYPE_CODE)) dcr_cmd_i (
    .clk(clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .active_mode(active_mode), .mfg_mode(mfg_mode),
    .opt_switch_up(opt_switch_up), .addr_switch_up(addr_switch_up),
    .board_flags(board_flags), .tbl_req(tbl_req), .tbl_data(tbl_data),
    .cfg(cfg), .switch_word(switch_word), .baud_fixed(baud_fixed));
  dcr_host dcr_host_i (
    .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .slow(slow));

  // table source; gain high byte is junk so a passed-through word shows
  function automatic logic [15:0] tbl_fn(dcr_pkg::dcr_req_type r);
    case (r.kind)
      dcr_pkg::TBL_FRAME: tbl_fn = salt ^ {7'h00, r.index} ^ 16'hF000;
      dcr_pkg::TBL_GAIN:  tbl_fn = {8'hC3, salt[7:0] ^ r.index[7:0]};
      default:            tbl_fn = salt ^ {7'h00, r.index};
    endcase
  endfunction
  // always_comb also follows salt, which the function reads
  always_comb tbl_data = tbl_fn(tbl_req);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input int exp);
    compares++;
    if (exp >= 0 && got !== exp[7:0]) begin
      error_cnt++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp[7:0]);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_cfg();
    check_word({4'h0, cfg.contrast}, m_con[15:0]);
    check_word(cfg.bias, m_bias[15:0]);
    check_word({8'h00, cfg.ib_mode}, m_ib[15:0]);
    check_word({14'h0, cfg.roll, cfg.lights}, {14'h0, m_roll[0], m_lit[0]});
  endtask

  // a negative value marks a word whose content is free
  task automatic push_w(input int v);
    exp_q.push_back(v < 0 ? -1 : v & 255);
    exp_q.push_back(v < 0 ? -1 : (v >> 8) & 255);
  endtask

  task automatic push_1(input int ok);
    exp_q.push_back(ok ? int'(dcr_pkg::BYTE_ACK) : int'(dcr_pkg::BYTE_NACK));
  endtask

  // send a command, collect its reply and compare the whole reply
  task automatic do_cmd(input logic [7:0] c, input int n, input int arg);
    int k;
    dcr_host_i.send(c);
    if (n > 0) dcr_host_i.send(arg[7:0]);
    if (n > 1) dcr_host_i.send(arg[15:8]);
    k = 0;
    while (dcr_host_i.got_q.size() < exp_q.size() && k < 9000) begin
      @(negedge clk);
      k++;
    end
    repeat (4) @(negedge clk);
    check_word(16'(dcr_host_i.got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      if (i < dcr_host_i.got_q.size())
        check_byte(dcr_host_i.got_q[i], exp_q[i]);
    exp_q.delete();
    dcr_host_i.got_q.delete();
    check_cfg();
  endtask

  task automatic echo(input dcr_pkg::dcr_tbl_type t, input logic [7:0] id);
    dcr_pkg::dcr_req_type r;
    exp_q.push_back(int'(id));
    r.kind = t;
    for (int ch = 0; ch < 480; ch++) begin
      r.index = 9'(ch);
      push_w(t == dcr_pkg::TBL_GAIN ? tbl_fn(r) & 255 : tbl_fn(r));
    end
  endtask

  task automatic status_exp();
    dcr_pkg::dcr_req_type r;
    int v, b, s;
    exp_q.push_back(int'(dcr_pkg::CMD_STATUS));
    r.kind = dcr_pkg::TBL_STATUS;
    for (int w = 0; w < 148; w++) begin
      r.index = 9'(w);
      v = tbl_fn(r);
      b = (w - 8) / 14;
      s = (w - 8) % 14;
      if (w == 3) v = -1;
      if (w == 7) v = {~addr_switch_up, ~opt_switch_up};
      if (w >= 8 && s == 0) v = {board_flags[b], 4'h0, 4'(b)};
      if (w >= 8 && s == 11 && b > 0) v = 1;
      push_w(v);
    end
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  initial begin
    void'($urandom(84344));
    reset = 1'b1;
    active_mode = 1'b0;
    mfg_mode = 1'b0;
    slow = 1'b0;
    opt_switch_up = 8'($urandom);
    addr_switch_up = 8'($urandom);
    salt = 16'($urandom);
    for (int i = 0; i < 10; i++) board_flags[i] = 8'($urandom);
    {m_con, m_bias, m_ib, m_roll, m_lit} =
      {32'd0, 32'h159, 32'd2, 32'd0, 32'd1};
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check_cfg();
    check_word({8'h00, switch_word[7:0]}, {8'h00, ~opt_switch_up});
    check_word({8'h00, switch_word[15:8]}, {8'h00, ~addr_switch_up});
    check_word({15'h0, baud_fixed},
               {15'h0, opt_switch_up[1:0] == 2'b00});
    opt_switch_up[1:0] = 2'b00;
    repeat (4) @(negedge clk);
    check_word({15'h0, baud_fixed}, 16'h0001);
    push_1(0);
    do_cmd(8'h41, 0, 0);
    push_1(0);
    do_cmd(8'h00, 0, 0);
    exp_q = '{int'(dcr_pkg::CMD_TYPE), int'(TYPE_CODE[7:0]),
              int'(TYPE_CODE[15:8])};
    do_cmd(dcr_pkg::CMD_TYPE, 0, 0);
    for (int i = 0; i < 2; i++) begin
      push_1(1);
      m_roll ^= 1;
      do_cmd(dcr_pkg::CMD_ROLL, 0, 0);
      push_1(1);
      m_lit ^= 1;
      do_cmd(dcr_pkg::CMD_LIGHTS, 0, 0);
    end
    // 4097 stands for a setting of zero, the maximum contrast
    for (int v = 4095; v <= 4097; v++) begin
      push_1(v == 4095 || v == 4097);
      if (v != 4096) m_con = (v == 4097) ? 0 : v;
      do_cmd(dcr_pkg::CMD_CONTRAST, 2, v == 4097 ? 0 : v);
    end
    push_1(0);
    do_cmd(dcr_pkg::CMD_BIAS, 2, 16'h0300);
    mfg_mode = 1'b1;
    active_mode = 1'b1;
    m_bias = 16'h0159;
    repeat (2) @(negedge clk);
    push_1(1);
    m_bias = 16'h0300;
    do_cmd(dcr_pkg::CMD_BIAS, 2, 16'h0300);
    active_mode = 1'b0;
    repeat (2) @(negedge clk);
    active_mode = 1'b1;
    m_bias = 16'h0159;
    push_1(0);
    do_cmd(dcr_pkg::CMD_INBUS, 1, 3);
    push_1(1);
    m_bias = 16'h0082;
    do_cmd(dcr_pkg::CMD_BIAS, 2, 16'h0082);
    mfg_mode = 1'b0;
    active_mode = 1'b0;
    for (int a = 5; a >= 1; a--) begin
      push_1(a >= 2 && a <= 4);
      if (a >= 2 && a <= 4) m_ib = a;
      do_cmd(dcr_pkg::CMD_INBUS, 1, a);
    end
    slow = 1'b1;
    status_exp();
    do_cmd(dcr_pkg::CMD_STATUS, 0, 0);
    echo(dcr_pkg::TBL_FRAME, dcr_pkg::CMD_FRAME);
    do_cmd(dcr_pkg::CMD_FRAME, 0, 0);
    slow = 1'b0;
    echo(dcr_pkg::TBL_GAIN, dcr_pkg::CMD_GAIN);
    do_cmd(dcr_pkg::CMD_GAIN, 0, 0);
    summarize();
  end
endmodule
